// File: pkg/qsfcf_regs.svh
/*
 Constants of the serial flash command framer: opcodes, frame lengths,
 dummy-cycle counts and field positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef QSFCF_REGS_SVH
`define QSFCF_REGS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define QSFCF_OP_RDSR1 8'h05
`define QSFCF_OP_RDSR2 8'h35
`define QSFCF_OP_RDSR3 8'h15
`define QSFCF_OP_WRSR1 8'h01
`define QSFCF_OP_WRSR2 8'h31
`define QSFCF_OP_WRSR3 8'h11
`define QSFCF_OP_SLEEP 8'hB9
`define QSFCF_OP_WAKE 8'hAB
`define QSFCF_OP_MFID 8'h90
`define QSFCF_OP_RSTEN 8'h66
`define QSFCF_OP_RST 8'h99
`define QSFCF_OP_DUALIO 8'hBB
`define QSFCF_OP_DUALOUT 8'h3B
`define QSFCF_OP_QUADIO 8'hEB
`define QSFCF_OP_QUADWORD 8'hE7
`define QSFCF_OP_QUADOUT 8'h6B
`define QSFCF_OP_WRAPRD 8'h0C
`define QSFCF_OP_SETPAR 8'hC0
`define QSFCF_OP_QPI_ON 8'h38
`define QSFCF_OP_QPI_OFF 8'hFF
`define QSFCF_OP_SECRD 8'h48
`define QSFCF_OP_SECPG 8'h42
`define QSFCF_OP_SECER 8'h44

// ----------------------------------------------------------------
// Security register address fields
// ----------------------------------------------------------------
`define QSFCF_SEC_TOP 8'h00
`define QSFCF_SEC_REG1 8'h10
`define QSFCF_SEC_REG2 8'h20

// ----------------------------------------------------------------
// Bit counts and dummy clocks
// ----------------------------------------------------------------
`define QSFCF_ADDR_BITS 6'h18
`define QSFCF_MODE_BITS 6'h08
`define QSFCF_QIO_DUMMY 4'h4
`define QSFCF_QWORD_DUMMY 4'h2
`define QSFCF_SPI_DUMMY 4'h8
`define QSFCF_CONT_CODE 2'h2
`define QSFCF_CNT_ONE 6'h01
`define QSFCF_BYTE_MASK 6'h07
`define QSFCF_LANE_W 4

`endif

// File: pkg/qsfcf_pkg.sv
/*
 Types of the serial flash command framer.
 Assumes the constants header is compiled alongside.
*/
package qsfcf_pkg;

	// ----------------------------------------------------------------
	// Frame phases, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		QSFCF_IDLE = 6'h01, // Waiting for chip select
		QSFCF_CMD = 6'h02, // Shifting in the opcode
		QSFCF_ADDR = 6'h04, // Address and mode bits
		QSFCF_DUMMY = 6'h08, // Don't-care clocks
		QSFCF_DOUT = 6'h10, // Driving data
		QSFCF_DIN = 6'h20 // Taking data bytes
	} qsfcf_phase_e;

	// Lane group carrying output value and enables
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} qsfcf_lanes_s;

	// Status bytes seen by the array side
	typedef struct packed {
		logic [7:0] s3;
		logic [7:0] s2;
		logic [7:0] s1;
	} qsfcf_status_s;

endpackage

// File: logic/qsfcf_sync.sv
/*
 Two-flop synchroniser with rise and fall detection on the second stage.
 Assumes an input from outside the system clock domain.
*/
`timescale 1ns/10ps

module qsfcf_sync (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Raw and synchronised level
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic meta; // First stage, read only by the second
		logic s2; // Second stage
		logic s3; // Edge history
	} qsfcf_sync_s;

	qsfcf_sync_s st, next_st;

	// Shift chain
	always_comb begin
		next_st = st;
		next_st.meta = async_i;
		next_st.s2 = st.meta;
		next_st.s3 = st.s2;
	end

	// Registers
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.s2;
	assign rise_o = st.s2 & ~st.s3;
	assign fall_o = ~st.s2 & st.s3;

endmodule // qsfcf_sync

// File: logic/qsfcf_framer.sv
/*
 Device-side opcode decoder and lane framer of a quad serial NOR flash.
 Chip select and serial clock come from the host and are oversampled by
 the system clock; the host clock must be well below a quarter of it.
 Memory data arrives on rd_data_i from the array side, which is outside.
*/
`timescale 1ns/10ps
`include "qsfcf_regs.svh"

module qsfcf_framer (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Link pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] lane_in_i,
	output qsfcf_pkg::qsfcf_lanes_s lanes_o,
	// Array side
	input wire logic [7:0] rd_data_i,
	input wire logic [7:0] device_id_i,
	input wire logic [7:0] mfr_id_i,
	input wire qsfcf_pkg::qsfcf_status_s status_i,
	output logic [23:0] addr_o,
	output logic [7:0] opcode_o,
	output logic cmd_done_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o,
	output logic [1:0] status_sel_o,
	output logic status_wr_o,
	output logic sec_sel_o,
	output logic soft_reset_o,
	output logic power_down_o,
	output logic four_lane_command_mode_o,
	output logic [7:0] read_parameter_bits_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic cs_n, cs_rise, cs_fall, sclk_lvl, sclk_rise, sclk_fall;
	logic [3:0] lane_s;

	qsfcf_sync u_cs (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .async_i(cs_n_i),
		.level_o(cs_n), .rise_o(cs_rise), .fall_o(cs_fall));
	qsfcf_sync u_ck (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .async_i(sclk_i),
		.level_o(sclk_lvl), .rise_o(sclk_rise), .fall_o(sclk_fall));

	// Data lanes share the same latency as the clock edge they pair with
	genvar g;
	generate
		for (g = 0; g < `QSFCF_LANE_W; g++) begin : g_lane
			qsfcf_sync u_ln (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .async_i(lane_in_i[g]),
				.level_o(lane_s[g]), .rise_o(), .fall_o());
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		qsfcf_pkg::qsfcf_phase_e ph;
		logic [7:0] op; // Opcode of this frame
		logic [23:0] addr; // Shifted-in address
		logic [7:0] sh; // Input shift register
		logic [7:0] mode; // Continuous read mode bits
		logic [5:0] bits; // Bits left in phase
		logic [5:0] total; // Serial clocks since select, modulo 64
		logic [3:0] dum; // Dummy clocks left
		logic [7:0] obuf; // Output byte
		logic [3:0] obits; // Bits left in output byte
		logic [2:0] width; // Lanes in use: 1, 2 or 4
		logic four_lane_command_mode;
		logic cont; // Next dual frame skips opcode
		logic rst_arm; // Reset enable seen in last frame
		logic sleep;
		logic [7:0] rpar;
		qsfcf_pkg::qsfcf_lanes_s lanes;
		logic done, bvalid, swr, srst;
		logic [7:0] bdata;
	} qsfcf_state_s;

	qsfcf_state_s st, next_st;

	// Whether an opcode carries an address phase
	function automatic logic has_addr(input logic [7:0] op);
		has_addr = (op == `QSFCF_OP_DUALIO) || (op == `QSFCF_OP_QUADIO) || (op == `QSFCF_OP_QUADWORD) ||
			(op == `QSFCF_OP_DUALOUT) || (op == `QSFCF_OP_QUADOUT) || (op == `QSFCF_OP_WRAPRD) ||
			(op == `QSFCF_OP_SECRD) || (op == `QSFCF_OP_SECPG) || (op == `QSFCF_OP_SECER) ||
			(op == `QSFCF_OP_MFID);
	endfunction

	// Dummy clocks selected by read parameter bits 5:4
	function automatic logic [3:0] qpi_dummy(input logic [7:0] p);
		case (p[5:4])
			2'h0: qpi_dummy = 4'h4;
			2'h1: qpi_dummy = 4'h6;
			default: qpi_dummy = 4'h8;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] shin;
		logic [2:0] win;
		logic [7:0] b;
		shin = '0;
		win = st.width;
		b = st.obuf;
		next_st = st;
		next_st.done = 1'b0;
		next_st.bvalid = 1'b0;
		next_st.swr = 1'b0;
		next_st.srst = 1'b0;
		// Input shift by current lane count
		case (win)
			3'h2: shin = {st.sh[5:0], lane_s[1:0]};
			3'h4: shin = {st.sh[3:0], lane_s};
			default: shin = {st.sh[6:0], lane_s[0]};
		endcase
		if (cs_fall) begin
			// New frame: continuous mode jumps straight to the address
			next_st.total = '0;
			next_st.lanes.oe = '0;
			if (st.cont) begin
				next_st.ph = qsfcf_pkg::QSFCF_ADDR;
				next_st.width = 3'h2;
				next_st.bits = `QSFCF_ADDR_BITS + `QSFCF_MODE_BITS;
			end else begin
				next_st.ph = qsfcf_pkg::QSFCF_CMD;
				next_st.width = st.four_lane_command_mode ? 3'h4 : 3'h1;
				next_st.bits = 6'h08;
			end
		end else if (cs_rise || cs_n) begin
			if (cs_rise && st.ph != qsfcf_pkg::QSFCF_IDLE) begin
				// Done, reset and sleep only act on a deselect after a multiple of 8 clocks
				if ((st.total & `QSFCF_BYTE_MASK) == 6'h00) begin
					next_st.done = (st.ph == qsfcf_pkg::QSFCF_DIN) || (st.ph == qsfcf_pkg::QSFCF_CMD);
					next_st.rst_arm = (st.op == `QSFCF_OP_RSTEN);
					next_st.srst = st.rst_arm && (st.op == `QSFCF_OP_RST);
					if (st.op == `QSFCF_OP_SLEEP) next_st.sleep = 1'b1;
				end else begin
					next_st.rst_arm = 1'b0;
				end
			end
			next_st.ph = qsfcf_pkg::QSFCF_IDLE;
			next_st.lanes.oe = '0;
		end else if (sclk_rise) begin
			next_st.total = st.total + `QSFCF_CNT_ONE;
			case (st.ph)
				qsfcf_pkg::QSFCF_CMD: begin
					next_st.sh = shin;
					next_st.bits = st.bits - {3'h0, win};
					if (st.bits == {3'h0, win}) begin
						next_st.op = shin;
						next_st.addr = '0;
						if (shin == `QSFCF_OP_WAKE) next_st.sleep = 1'b0;
						if (has_addr(shin) && !(shin == `QSFCF_OP_WRAPRD && !st.four_lane_command_mode)) begin
							next_st.ph = qsfcf_pkg::QSFCF_ADDR;
							next_st.width = st.four_lane_command_mode ? 3'h4 : ((shin == `QSFCF_OP_DUALIO) ? 3'h2 :
								((shin == `QSFCF_OP_QUADIO || shin == `QSFCF_OP_QUADWORD) ? 3'h4 : 3'h1));
							next_st.bits = `QSFCF_ADDR_BITS + (((shin == `QSFCF_OP_DUALIO) ||
								(shin == `QSFCF_OP_QUADIO) || (shin == `QSFCF_OP_QUADWORD)) ? `QSFCF_MODE_BITS : 6'h00);
						end else if (shin == `QSFCF_OP_WAKE) begin
							// Single-lane wake has no dummy clocks: the ID follows at once
							next_st.ph = st.four_lane_command_mode ? qsfcf_pkg::QSFCF_DUMMY : qsfcf_pkg::QSFCF_DOUT;
							next_st.obits = 4'h0;
							next_st.dum = st.four_lane_command_mode ? qpi_dummy(st.rpar) : 4'h0;
						end else if (shin == `QSFCF_OP_RDSR1 || shin == `QSFCF_OP_RDSR2 ||
							shin == `QSFCF_OP_RDSR3) begin
							next_st.ph = qsfcf_pkg::QSFCF_DOUT;
							next_st.obits = 4'h0;
						end else begin
							// Status writes, set parameters and others take data bytes
							next_st.ph = qsfcf_pkg::QSFCF_DIN;
							next_st.bits = 6'h08;
						end
						if (shin == `QSFCF_OP_QPI_OFF) begin
							if (st.cont) next_st.cont = 1'b0;
							else next_st.four_lane_command_mode = 1'b0;
						end
					end
				end
				qsfcf_pkg::QSFCF_ADDR: begin
					next_st.bits = st.bits - {3'h0, win};
					// Only the dual and quad I/O reads carry mode bits after the address
					if (st.bits > `QSFCF_MODE_BITS || !(st.op == `QSFCF_OP_DUALIO ||
						st.op == `QSFCF_OP_QUADIO || st.op == `QSFCF_OP_QUADWORD))
						next_st.addr = (win == 3'h4) ? {st.addr[19:0], lane_s} :
							(win == 3'h2) ? {st.addr[21:0], lane_s[1:0]} : {st.addr[22:0], lane_s[0]};
					else
						next_st.mode = shin;
					next_st.sh = shin;
					if (st.bits == {3'h0, win}) begin
						next_st.ph = qsfcf_pkg::QSFCF_DUMMY;
						if (st.op == `QSFCF_OP_DUALIO || st.op == `QSFCF_OP_QUADIO || st.op == `QSFCF_OP_QUADWORD)
							next_st.cont = (shin[5:4] == `QSFCF_CONT_CODE);
						case (st.op)
							`QSFCF_OP_QUADIO: next_st.dum = st.four_lane_command_mode ? qpi_dummy(st.rpar) : `QSFCF_QIO_DUMMY;
							`QSFCF_OP_QUADWORD: next_st.dum = `QSFCF_QWORD_DUMMY;
							`QSFCF_OP_DUALIO: next_st.dum = 4'h0;
							`QSFCF_OP_MFID: next_st.dum = st.four_lane_command_mode ? qpi_dummy(st.rpar) : 4'h0;
							`QSFCF_OP_SECPG, `QSFCF_OP_SECER: begin
								next_st.ph = qsfcf_pkg::QSFCF_DIN;
								next_st.bits = 6'h08;
							end
							default: next_st.dum = st.four_lane_command_mode ? qpi_dummy(st.rpar) : `QSFCF_SPI_DUMMY;
						endcase
						if (st.op == `QSFCF_OP_QUADOUT) next_st.width = 3'h4;
						else if (st.op == `QSFCF_OP_DUALOUT) next_st.width = 3'h2;
						// No dummy clocks: drive data on the very next falling edge
						if (next_st.ph == qsfcf_pkg::QSFCF_DUMMY && next_st.dum == 4'h0)
							next_st.ph = qsfcf_pkg::QSFCF_DOUT;
						next_st.obits = 4'h0;
					end
				end
				qsfcf_pkg::QSFCF_DUMMY: begin
					if (st.dum <= 4'h1) next_st.ph = qsfcf_pkg::QSFCF_DOUT;
					next_st.dum = (st.dum == 4'h0) ? 4'h0 : st.dum - 4'h1;
					next_st.obits = 4'h0;
				end
				qsfcf_pkg::QSFCF_DIN: begin
					next_st.sh = shin;
					next_st.bits = st.bits - {3'h0, win};
					if (st.bits == {3'h0, win}) begin
						next_st.bits = 6'h08;
						next_st.bvalid = 1'b1;
						next_st.bdata = shin;
						next_st.swr = (st.op == `QSFCF_OP_WRSR1 || st.op == `QSFCF_OP_WRSR2 ||
							st.op == `QSFCF_OP_WRSR3);
						if (st.op == `QSFCF_OP_SETPAR) next_st.rpar = shin;
						if (st.op == `QSFCF_OP_QPI_ON && status_i.s2[1]) next_st.four_lane_command_mode = 1'b1;
					end
				end
				default: ;
			endcase
			// Opcode-only enable of four-lane mode
			if (st.ph == qsfcf_pkg::QSFCF_CMD && st.bits == {3'h0, win} && shin == `QSFCF_OP_QPI_ON)
				next_st.four_lane_command_mode = 1'b1;
		end else if (sclk_fall && st.ph == qsfcf_pkg::QSFCF_DOUT) begin
			// Shift out on falling edge, reload a fresh byte when empty
			if (st.obits == 4'h0) begin
				case (st.op)
					`QSFCF_OP_RDSR1: b = status_i.s1;
					`QSFCF_OP_RDSR2: b = status_i.s2;
					`QSFCF_OP_RDSR3: b = status_i.s3;
					`QSFCF_OP_WAKE: b = device_id_i;
					`QSFCF_OP_MFID: b = st.addr[0] ? device_id_i : mfr_id_i;
					default: b = rd_data_i;
				endcase
				next_st.obits = 4'h8;
				next_st.addr = st.addr + 24'h1;
			end
			next_st.lanes.oe = (st.width == 3'h4) ? 4'hF : (st.width == 3'h2) ? 4'h3 : 4'h2;
			case (st.width)
				3'h4: begin
					next_st.lanes.out = b[7:4];
					next_st.obuf = {b[3:0], 4'h0};
				end
				3'h2: begin
					next_st.lanes.out = {2'h0, b[7:6]};
					next_st.obuf = {b[5:0], 2'h0};
				end
				default: begin
					next_st.lanes.out = {2'h0, b[7], 1'b0};
					next_st.obuf = {b[6:0], 1'b0};
				end
			endcase
			next_st.obits = ((st.obits == 4'h0) ? 4'h8 : st.obits) - {1'b0, st.width};
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
			st.ph <= qsfcf_pkg::QSFCF_IDLE;
			st.width <= 3'h1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign lanes_o = st.lanes;
	assign addr_o = st.addr;
	assign opcode_o = st.op;
	assign cmd_done_o = st.done;
	assign byte_valid_o = st.bvalid;
	assign byte_o = st.bdata;
	assign status_sel_o = (st.op == `QSFCF_OP_WRSR2) ? 2'h1 : (st.op == `QSFCF_OP_WRSR3) ? 2'h2 : 2'h0;
	assign status_wr_o = st.swr;
	// Second security register when top byte is 00H and middle byte is 20H
	assign sec_sel_o = (st.addr[15:8] == `QSFCF_SEC_REG2) && (st.addr[23:16] == `QSFCF_SEC_TOP);
	assign soft_reset_o = st.srst;
	assign power_down_o = st.sleep;
	assign four_lane_command_mode_o = st.four_lane_command_mode;
	assign read_parameter_bits_o = st.rpar;

endmodule // qsfcf_framer

// File: bench/qsfcf_framer_assertions.sv
/*
 Port checker of the flash command framer.
 Assumes a bind to qsfcf_framer and one system clock domain.
*/
`timescale 1ns/10ps

module qsfcf_framer_chk (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Watched ports
	input wire logic cs_n_i,
	input wire qsfcf_pkg::qsfcf_lanes_s lanes_o,
	input wire logic [7:0] opcode_o,
	input wire logic cmd_done_o,
	input wire logic byte_valid_o,
	input wire logic [1:0] status_sel_o,
	input wire logic status_wr_o,
	input wire logic soft_reset_o,
	input wire logic power_down_o,
	input wire logic four_lane_command_mode_o,
	input wire logic [7:0] read_parameter_bits_o
);
	// ----
	// Sequences
	// ----
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	// Long deselect, past the select synchroniser
	sequence s_idle;
		cs_n_i [*6];
	endsequence
	// Single-cycle reset request
	sequence s_one_pulse;
		soft_reset_o ##1 !soft_reset_o;
	endsequence
	// ----
	// Assertions
	// ----
	a_lanes_release: assert property (s_idle |-> lanes_o.oe == 4'h0)
		else $error("lanes driven while idle");
	a_write_pair: assert property (status_wr_o |-> byte_valid_o && opcode_o inside {8'h01, 8'h31, 8'h11})
		else $error("status write without byte");
	a_write_select: assert property (status_wr_o |->
		status_sel_o == (opcode_o == 8'h01 ? 2'h0 : (opcode_o == 8'h31 ? 2'h1 : 2'h2)))
		else $error("wrong status byte chosen");
	a_reset_pulse: assert property (soft_reset_o |-> (cs_n_i && opcode_o == 8'h99) ##0 s_one_pulse)
		else $error("bad reset pulse");
	a_done_deselect: assert property (cmd_done_o |-> cs_n_i ##1 !cmd_done_o)
		else $error("done outside deselect");
	a_sleep_entry: assert property ($rose(power_down_o) |-> cs_n_i && opcode_o == 8'hB9)
		else $error("sleep without its opcode");
	a_sleep_exit: assert property ($fell(power_down_o) |-> !cs_n_i && opcode_o == 8'hAB)
		else $error("wake without its opcode");
	a_param_write: assert property ($changed(read_parameter_bits_o) |-> opcode_o == 8'hC0)
		else $error("parameter changed by other opcode");
	a_lane_mode: assert property ($changed(four_lane_command_mode_o) |-> opcode_o inside {8'h38, 8'hFF, 8'h99})
		else $error("lane mode changed by other opcode");
endmodule // qsfcf_framer_chk

bind qsfcf_framer qsfcf_framer_chk qsfcf_framer_chk_inst (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.cs_n_i(cs_n_i),
	.lanes_o(lanes_o),
	.opcode_o(opcode_o),
	.cmd_done_o(cmd_done_o),
	.byte_valid_o(byte_valid_o),
	.status_sel_o(status_sel_o),
	.status_wr_o(status_wr_o),
	.soft_reset_o(soft_reset_o),
	.power_down_o(power_down_o),
	.four_lane_command_mode_o(four_lane_command_mode_o),
	.read_parameter_bits_o(read_parameter_bits_o)
);

// File: bench/qsfcf_host.sv
/*
 Behavioural SPI host driving the framer's link pins.
 Assumes one task call at a time; serial clock idles low.
*/
`timescale 1ns/10ps

module qsfcf_host (
	// Link pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] lane_o,
	// Device drive
	input wire qsfcf_pkg::qsfcf_lanes_s lanes_i
);
	logic [3:0] drv = 4'h0; // Lanes the host drives
	logic [3:0] val = 4'h0; // Host lane values
	// Undriven lanes show the inverse, so a stale value never passes
	assign lane_o = (lanes_i.oe & lanes_i.out) | (~lanes_i.oe & ((drv & val) | (~drv & ~val)));
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
	end
	// Select edge with gaps; odd delay keeps phase apart from the system clock
	task automatic sel(input logic on);
		#207 cs_n_o = !on;
		#200;
	endtask
	// n clocks of w bits, MSB first; samples device lanes late in each clock
	task automatic xfer(input int w, input int n, input logic [31:0] d, input logic hd, output logic [31:0] q);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		q = 32'h0;
		drv = hd ? m : 4'h0;
		for (int i = n - 1; i >= 0; i--) begin
			val = 4'(d >> (i * w)) & m;
			#160 sclk_o = 1'b1;
			#159 q = (q << w) | 32'((w == 1) ? {3'h0, lanes_i.out[1]} : lanes_i.out & m);
			#1 sclk_o = 1'b0;
		end
		drv = 4'h0;
	endtask
endmodule // qsfcf_host

// File: bench/test_quad_spi_flash_command_framing.sv
/*
 Bench of the flash command framer with a host model.
 Assumes framer, checker and host model compile first.
*/
`timescale 1ns/10ps

module test_quad_spi_flash_command_framing;
	// ----
	// Signals
	// ----
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cs_n, sclk, done, bval, swr, sec, srst, pd, four_lane_command_mode;
	logic [3:0] lane_in;
	qsfcf_pkg::qsfcf_lanes_s lanes;
	qsfcf_pkg::qsfcf_status_s status = 24'h0;
	logic [7:0] rd_data = 8'h00, dev_id = 8'h00, mfr_id = 8'h00, key = 8'h00;
	logic [7:0] opc, byte_v, rpar, b, wr_byte;
	logic [23:0] addr, a;
	logic [1:0] ssel, wr_sel;
	logic [31:0] r; // Bits the host took
	int error_cnt = 0, samples_checked = 0, rst_cnt = 0, done_cnt = 0, wr_cnt = 0, n;
	qsfcf_host qsfcf_host_inst (.cs_n_o(cs_n), .sclk_o(sclk), .lane_o(lane_in), .lanes_i(lanes));
	qsfcf_framer qsfcf_framer_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n),
		.sclk_i(sclk), .lane_in_i(lane_in), .lanes_o(lanes), .rd_data_i(rd_data), .device_id_i(dev_id),
		.mfr_id_i(mfr_id), .status_i(status), .addr_o(addr), .opcode_o(opc), .cmd_done_o(done),
		.byte_valid_o(bval), .byte_o(byte_v), .status_sel_o(ssel), .status_wr_o(swr), .sec_sel_o(sec),
		.soft_reset_o(srst), .power_down_o(pd), .four_lane_command_mode_o(four_lane_command_mode), .read_parameter_bits_o(rpar));
	always #20 clk_sys_i = ~clk_sys_i;
	// Array model: byte follows the address
	always @(negedge clk_sys_i) begin
		rd_data <= key ^ addr[7:0];
	end
	// Pulse monitor
	always @(posedge clk_sys_i) begin
		rst_cnt += (srst === 1'b1);
		done_cnt += (done === 1'b1);
		if (swr === 1'b1) begin
			wr_cnt++;
			wr_byte = byte_v;
			wr_sel = ssel;
		end
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Whole frame: opcode, address, dummies, then nr clocks read
	task automatic frame(input int wo, input logic [7:0] c, input int wa, input int na, input logic [31:0] av,
		input int nd, input int wd, input int nr);
		qsfcf_host_inst.sel(1'b1);
		if (wo > 0) qsfcf_host_inst.xfer(wo, 8 / wo, {24'h0, c}, 1'b1, r);
		if (na > 0) qsfcf_host_inst.xfer(wa, na, av, 1'b1, r);
		if (nd > 0) qsfcf_host_inst.xfer(1, nd, 32'h0, 1'b0, r);
		if (nr > 0) qsfcf_host_inst.xfer(wd, nr, 32'h0, 1'b0, r);
		qsfcf_host_inst.sel(1'b0);
	endtask
	task automatic op(input int w, input logic [7:0] c);
		frame(w, c, 1, 0, 32'h0, 0, 1, 0);
	endtask
	// Two bytes from address x onwards
	function automatic logic [31:0] two(input logic [23:0] x);
		return {16'h0, key ^ x[7:0], key ^ (x[7:0] + 8'h01)};
	endfunction
	task automatic print_verdict();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		error_cnt++;
		print_verdict();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		void'($urandom(32'h0FAF1D24));
		@(negedge clk_sys_i);
		key = 8'($urandom);
		dev_id = 8'($urandom);
		mfr_id = 8'($urandom);
		status = 24'($urandom) | 24'h000200;
		repeat (5) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		for (int i = 0; i < 3; i++) begin
			frame(1, 8'(24'h153505 >> (8 * i)), 1, 0, 32'h0, 0, 1, 16);
			chk(r, {16'h0, status[8 * i +: 8], status[8 * i +: 8]});
			b = 8'($urandom);
			frame(1, 8'(24'h113101 >> (8 * i)), 1, 8, {24'h0, b}, 0, 1, 0);
			chk({wr_byte, 6'h0, wr_sel}, {b, 6'h0, 2'(i)});
		end
		chk(wr_cnt, 3);
		// Reset pairing, a misaligned enable and an intervening command
		n = done_cnt;
		op(1, 8'h66);
		chk(done_cnt, n + 1);
		op(1, 8'h99);
		chk(rst_cnt, 1);
		n = done_cnt;
		frame(1, 8'h66, 1, 3, 32'h0, 0, 1, 0);
		chk(done_cnt, n);
		op(1, 8'h99);
		op(1, 8'h66);
		frame(1, 8'h05, 1, 0, 32'h0, 0, 1, 8);
		op(1, 8'h99);
		chk(rst_cnt, 1);
		op(1, 8'h66);
		op(1, 8'h99);
		chk(rst_cnt, 2);
		op(1, 8'hB9);
		chk(pd, 1'b1);
		frame(1, 8'hAB, 1, 0, 32'h0, 0, 1, 8);
		chk({r[7:0], 7'h0, pd}, {dev_id, 8'h00});
		for (int i = 1; i < 3; i++) begin
			// Offset kept low so the read-ahead never carries into the register byte
			b = 8'($urandom) & 8'h7F;
			frame(1, 8'h48, 1, 24, {8'h00, 8'h00, 4'(i), 4'h0, b}, 8, 1, 8);
			chk({r[7:0], 7'h0, sec}, {key ^ b, 7'h0, 1'(i - 1)});
		end
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 24'hFFFFFF : 24'($urandom);
			frame(1, 8'h3B, 1, 24, {8'h00, a}, 8, 2, 8);
			chk(r, two(a));
		end
		for (int i = 0; i < 2; i++) begin
			a = 24'($urandom) & 24'hFFFFFE;
			frame(1, i ? 8'hE7 : 8'hEB, 4, 8, {a, 8'h00}, i ? 2 : 4, 4, 4);
			chk(r, two(a));
		end
		// Continuous mode arms, skips one opcode, then clears
		a = 24'($urandom);
		frame(1, 8'hBB, 2, 16, {a, 8'h20}, 0, 2, 4);
		chk(r, {24'h0, key ^ a[7:0]});
		a = 24'($urandom);
		frame(0, 8'h00, 2, 16, {a, 8'h00}, 0, 2, 8);
		chk(r, two(a));
		frame(1, 8'h05, 1, 0, 32'h0, 0, 1, 8);
		chk(r, {24'h0, status.s1});
		op(1, 8'h38);
		chk(four_lane_command_mode, 1'b1);
		for (int p = 0; p < 3; p++) begin
			b = (8'($urandom) & 8'hCF) | 8'(p << 4);
			frame(4, 8'hC0, 4, 2, {24'h0, b}, 0, 4, 0);
			chk(rpar, b);
			frame(4, 8'hAB, 4, 0, 32'h0, 4 + 2 * p, 4, 2);
			chk(r, {24'h0, dev_id});
		end
		frame(4, 8'h05, 4, 0, 32'h0, 0, 4, 4);
		chk(r, {16'h0, status.s1, status.s1});
		a = 24'($urandom);
		frame(4, 8'h0C, 4, 6, {8'h00, a}, 8, 4, 2);
		chk(r, {24'h0, key ^ a[7:0]});
		op(4, 8'hFF);
		chk(four_lane_command_mode, 1'b0);
		print_verdict();
	end
endmodule // test_quad_spi_flash_command_framing
